// ===== rtl/admc_pkg.sv
// Purpose: Shared constants for the audio DAC mode-control register bank
// Assumes: Control port pins are sampled synchronously to clk
// Notes:   Indexes are the 7-bit register indexes of the control word
package admc_pkg;

    // Control word layout (16 bits, MSB first)
    localparam int         WORD_BITS    = 16;
    localparam int         HDR_BITS     = 8;
    localparam logic [4:0] CNT_HDR_LAST = 5'h07;
    localparam logic [4:0] CNT_FIRST_RD = 5'h08;
    localparam logic [4:0] CNT_LAST     = 5'h0F;

    // Register indexes
    localparam logic [6:0] IDX_ATTEN_L  = 7'h10;
    localparam logic [6:0] IDX_ATTEN_R  = 7'h11;
    localparam logic [6:0] IDX_FORMAT   = 7'h12;
    localparam logic [6:0] IDX_OUT_CTRL = 7'h13;
    localparam logic [6:0] IDX_MODE     = 7'h14;
    localparam logic [6:0] IDX_ZERO_OUT = 7'h15;
    localparam logic [6:0] IDX_ZFLAGS   = 7'h16;
    localparam logic [6:0] IDX_NODE_ID  = 7'h17;
    localparam int         NUM_RW       = 6;

    // Reset values of the writable registers
    localparam logic [7:0] RST_ATTEN    = 8'hFF;
    localparam logic [7:0] RST_FORMAT   = 8'h50;
    localparam logic [7:0] RST_OUT_CTRL = 8'h00;
    localparam logic [7:0] RST_MODE     = 8'h00;
    localparam logic [7:0] RST_ZERO_OUT = 8'h01;

    // Writable-bit masks; reserved bits read as zero
    localparam logic [7:0] MASK_FULL     = 8'hFF;
    localparam logic [7:0] MASK_MODE     = 8'h7F;
    localparam logic [7:0] MASK_ZERO_OUT = 8'h07;

    // Format/emphasis/mute register fields
    localparam int B_LOAD  = 7;
    localparam int B_FORM  = 4;
    localparam int B_RATE  = 2;
    localparam int B_EMPH  = 1;
    localparam int B_MUTE  = 0;
    // Output/filter register fields
    localparam int B_INV   = 7;
    localparam int B_STEP  = 5;
    localparam int B_DIS   = 4;
    localparam int B_ZPIN  = 3;
    localparam int B_BYST  = 2;
    localparam int B_ROLL  = 1;
    localparam int B_IZM   = 0;
    // Mode register fields
    localparam int B_SRES  = 6;
    localparam int B_STRM  = 5;
    localparam int B_BYP   = 4;
    localparam int B_MONO  = 3;
    localparam int B_SRC   = 2;
    localparam int B_OVS   = 0;
    // Zero-output register fields
    localparam int B_SZO   = 1;
    localparam int B_PZO   = 0;

    // Field defaults used while a mode ignores a field, and the attenuation mute code limit
    localparam logic [2:0] FORM_I2S24   = 3'h5;
    localparam logic [1:0] RATE_OFF     = 2'h0;
    localparam logic [1:0] OVS_X64      = 2'h0;
    localparam logic [7:0] ATTEN_MUTE_MAX = 8'h0E;

    // Serial port sequencer states
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_DONE  = 2'b10
    } admc_port_state_t;

endpackage : admc_pkg

// ===== rtl/admc_regs.sv
// Purpose: Mode-control register bank of a stereo audio converter
// Assumes: Control port pins and status inputs synchronous to clk
// Notes:   Settings are driven to the datapath gated by input mode
//
// Contract
// - Word top bit 1 reads, 0 writes
// - Indexes 22 and 23 ignore writes
// - Per-channel attenuation codes, reset 0 dB
// - Load enable resets disabled, gates attenuation
// - Format field, reset 24-bit I2S
// - De-emphasis rate and enable reset disabled
// - Stream mode reinterprets rate and oversample fields
// - Soft mute resets off, PCM only
// - Phase invert resets normal, all modes
// - Converter disable bit resets enabled
// - Zero pin function resets data input
// - Bypass stereo select resets mono
// - Rolloff select resets sharp
// - Infinite zero mute resets disabled
// - Soft system reset resets normal
// - Stream mode enable resets disabled
// - Filter bypass resets internal filter
// - Mono and source select reset stereo/left
// - Oversample field resets to x64
// - PCM zero out on, stream zero off
// - Index 22 reports per-channel zero flags
// - Index 23 returns 5-bit node identifier
// - Attenuation follows registers only while enabled in PCM mode
// - Codes 0 to 14 mean mute
// - Format codes 110 and 111 reserved
// - De-emphasis rate code mapping
`timescale 1ns/10ps
module admc_regs
    import admc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Control port pins
    input  wire logic       ms_n,
    input  wire logic       mc,
    input  wire logic       mdi,
    output logic            mdo,
    // Datapath status
    input  wire logic       left_zero_detect,
    input  wire logic       right_zero_detect,
    input  wire logic [4:0] node_identifier,
    // Attenuation
    output logic [7:0]      left_atten_level,
    output logic [7:0]      right_atten_level,
    output logic            left_atten_mute,
    output logic            right_atten_mute,
    output logic [1:0]      atten_step_rate,
    // Format and filtering
    output logic [2:0]      audio_format_sel,
    output logic [1:0]      deemph_rate_sel,
    output logic            deemph_enable,
    output logic            soft_mute,
    output logic            rolloff_sel,
    output logic            bypass_stereo_sel,
    // Output control
    output logic            phase_invert,
    output logic            converter_disable,
    output logic            zero_pin_function,
    output logic            infinite_zero_mute,
    // Mode selection
    output logic            soft_system_reset,
    output logic            one_bit_stream_mode,
    output logic            filter_bypass,
    output logic            mono_mode,
    output logic            mono_source_sel,
    output logic [1:0]      oversample_rate_sel,
    output logic [1:0]      fir_perf_sel,
    output logic [1:0]      fir_rate_sel,
    // Zero output control
    output logic            pcm_zero_out_enable,
    output logic [1:0]      stream_zero_out_sel
);

    // Writable register storage, indexed from the first index
    logic [7:0] ctrl_reg [NUM_RW];
    logic [7:0] ctrl_next [NUM_RW];
    logic [1:0] zflag_reg, zflag_next;     // Sampled zero flags
    logic [4:0] node_reg, node_next;       // Sampled identifier

    // Port signals
    logic [6:0] cmd_index;                 // Latched index
    logic       cmd_rw;                    // Latched read flag
    logic       wr_valid;                  // Write strobe
    logic [7:0] wr_data;                   // Write data
    logic [7:0] rd_data;                   // Readback value

    // Applied settings
    logic [7:0] attl_reg, attl_next;
    logic [7:0] attr_reg, attr_next;
    logic       mutel_reg, mutel_next;
    logic       muter_reg, muter_next;
    logic [1:0] step_reg, step_next;
    logic [2:0] form_reg, form_next;
    logic [1:0] rate_reg, rate_next;
    logic       emph_reg, emph_next;
    logic       smute_reg, smute_next;
    logic       roll_reg, roll_next;
    logic       byst_reg, byst_next;
    logic       inv_reg, inv_next;
    logic       dis_reg, dis_next;
    logic       zpin_reg, zpin_next;
    logic       izm_reg, izm_next;
    logic       sres_reg, sres_next;
    logic       strm_reg, strm_next;
    logic       byp_reg, byp_next;
    logic       mono_reg, mono_next;
    logic       src_reg, src_next;
    logic [1:0] ovs_reg, ovs_next;
    logic [1:0] firp_reg, firp_next;
    logic [1:0] firr_reg, firr_next;
    logic       pzo_reg, pzo_next;
    logic [1:0] szo_reg, szo_next;

    // Mode decode from stored bits
    logic       mode_stream;
    logic       mode_bypass;
    logic       mode_pcm;

    // True for an index that holds a writable register
    function automatic logic is_rw_index(input logic [6:0] idx);
        is_rw_index = (idx >= IDX_ATTEN_L) && (idx <= IDX_ZERO_OUT);
    endfunction : is_rw_index

    // Reset value per writable slot
    function automatic logic [7:0] reset_value(input int slot);
        case (slot)
            0, 1:    reset_value = RST_ATTEN;
            2:       reset_value = RST_FORMAT;
            3:       reset_value = RST_OUT_CTRL;
            4:       reset_value = RST_MODE;
            5:       reset_value = RST_ZERO_OUT;
            default: reset_value = 8'h00;
        endcase
    endfunction : reset_value

    // Writable-bit mask per index
    function automatic logic [7:0] write_mask(input logic [6:0] idx);
        case (idx)
            IDX_MODE:     write_mask = MASK_MODE;
            IDX_ZERO_OUT: write_mask = MASK_ZERO_OUT;
            default:      write_mask = MASK_FULL;
        endcase
    endfunction : write_mask

    // Codes at or below the mute limit silence the channel
    function automatic logic is_mute(input logic [7:0] level);
        is_mute = (level <= ATTEN_MUTE_MAX);
    endfunction : is_mute

    // Control port framer
    admc_serial_port u_port (
        .clk       (clk),
        .reset     (reset),
        .ms_n      (ms_n),
        .mc        (mc),
        .mdi       (mdi),
        .mdo       (mdo),
        .rd_data   (rd_data),
        .cmd_index (cmd_index),
        .cmd_rw    (cmd_rw),
        .wr_valid  (wr_valid),
        .wr_data   (wr_data)
    );

    // Readback multiplexer
    always_comb begin
        rd_data = 8'h00;
        if (is_rw_index(cmd_index)) begin
            rd_data = ctrl_reg[3'(cmd_index - IDX_ATTEN_L)];
        end else if (cmd_index == IDX_ZFLAGS) begin
            rd_data = {6'h00, zflag_reg};
        end else if (cmd_index == IDX_NODE_ID) begin
            rd_data = {3'h0, node_reg};
        end
    end

    // Register writes; read-only and unlisted indexes fall through
    always_comb begin
        for (int i = 0; i < NUM_RW; i++) begin
            ctrl_next[i] = ctrl_reg[i];
        end
        if (wr_valid && !cmd_rw && is_rw_index(cmd_index)) begin
            ctrl_next[3'(cmd_index - IDX_ATTEN_L)] =
                wr_data & write_mask(cmd_index);
        end
        zflag_next = {right_zero_detect, left_zero_detect};
        node_next  = node_identifier;
    end

    // Register storage
    always_ff @(posedge clk) begin
        if (reset) begin
            for (int i = 0; i < NUM_RW; i++) begin
                ctrl_reg[i] <= reset_value(i);
            end
            zflag_reg <= 2'h0;
            node_reg  <= 5'h00;
        end else begin
            for (int i = 0; i < NUM_RW; i++) begin
                ctrl_reg[i] <= ctrl_next[i];
            end
            zflag_reg <= zflag_next;
            node_reg  <= node_next;
        end
    end

    // Input mode; stream mode wins over bypass if both are set
    assign mode_stream = ctrl_reg[4][B_STRM];
    assign mode_bypass = ~mode_stream
                       & ctrl_reg[4][B_BYP];
    assign mode_pcm    = ~mode_stream & ~mode_bypass;

    // Applied settings derived from stored bits and mode
    always_comb begin
        // Attenuation holds until load is enabled in PCM mode
        attl_next = attl_reg;
        attr_next = attr_reg;
        if (mode_pcm && ctrl_reg[2][B_LOAD]) begin
            attl_next = ctrl_reg[0];
            attr_next = ctrl_reg[1];
        end
        mutel_next = is_mute(attl_next);
        muter_next = is_mute(attr_next);
        step_next  = ctrl_reg[3][B_STEP +: 2];

        // Format used by PCM and bypass modes
        form_next = FORM_I2S24;
        if (!mode_stream) begin
            form_next = ctrl_reg[2][B_FORM +: 3];
        end

        // Rate field is de-emphasis in PCM, FIR quality in stream
        rate_next = RATE_OFF;
        firp_next = RATE_OFF;
        if (mode_pcm) begin
            rate_next = ctrl_reg[2][B_RATE +: 2];
        end else if (mode_stream) begin
            firp_next = ctrl_reg[2][B_RATE +: 2];
        end
        emph_next  = mode_pcm & ctrl_reg[2][B_EMPH];
        smute_next = mode_pcm & ctrl_reg[2][B_MUTE];
        roll_next  = mode_pcm & ctrl_reg[3][B_ROLL];
        byst_next  = mode_bypass & ctrl_reg[3][B_BYST];

        // Output controls
        inv_next  = ctrl_reg[3][B_INV];
        dis_next  = ctrl_reg[3][B_DIS];
        zpin_next = ~mode_stream & ctrl_reg[3][B_ZPIN];
        izm_next  = ~mode_stream & ctrl_reg[3][B_IZM];

        // Mode controls
        sres_next = ctrl_reg[4][B_SRES];
        strm_next = mode_stream;
        byp_next  = mode_bypass;
        mono_next = ctrl_reg[4][B_MONO];
        src_next  = ctrl_reg[4][B_SRC];

        // Oversample field is FIR operation rate in stream mode
        ovs_next  = OVS_X64;
        firr_next = OVS_X64;
        if (mode_stream) begin
            firr_next = ctrl_reg[4][B_OVS +: 2];
        end else begin
            ovs_next = ctrl_reg[4][B_OVS +: 2];
        end

        // Zero output controls
        pzo_next = ctrl_reg[5][B_PZO];
        if (mode_stream) begin
            pzo_next = 1'b0;
        end
        szo_next = RATE_OFF;
        if (mode_stream) begin
            szo_next = ctrl_reg[5][B_SZO +: 2];
        end
    end

    // Applied-setting registers
    always_ff @(posedge clk) begin
        if (reset) begin
            attl_reg  <= RST_ATTEN;
            attr_reg  <= RST_ATTEN;
            mutel_reg <= 1'b0;
            muter_reg <= 1'b0;
            step_reg  <= 2'h0;
            form_reg  <= FORM_I2S24;
            rate_reg  <= RATE_OFF;
            firp_reg  <= RATE_OFF;
            emph_reg  <= 1'b0;
            smute_reg <= 1'b0;
            roll_reg  <= 1'b0;
            byst_reg  <= 1'b0;
            inv_reg   <= 1'b0;
            dis_reg   <= 1'b0;
            zpin_reg  <= 1'b0;
            izm_reg   <= 1'b0;
            sres_reg  <= 1'b0;
            strm_reg  <= 1'b0;
            byp_reg   <= 1'b0;
            mono_reg  <= 1'b0;
            src_reg   <= 1'b0;
            ovs_reg   <= OVS_X64;
            firr_reg  <= OVS_X64;
            pzo_reg   <= 1'b1;
            szo_reg   <= RATE_OFF;
        end else begin
            attl_reg  <= attl_next;
            attr_reg  <= attr_next;
            mutel_reg <= mutel_next;
            muter_reg <= muter_next;
            step_reg  <= step_next;
            form_reg  <= form_next;
            rate_reg  <= rate_next;
            firp_reg  <= firp_next;
            emph_reg  <= emph_next;
            smute_reg <= smute_next;
            roll_reg  <= roll_next;
            byst_reg  <= byst_next;
            inv_reg   <= inv_next;
            dis_reg   <= dis_next;
            zpin_reg  <= zpin_next;
            izm_reg   <= izm_next;
            sres_reg  <= sres_next;
            strm_reg  <= strm_next;
            byp_reg   <= byp_next;
            mono_reg  <= mono_next;
            src_reg   <= src_next;
            ovs_reg   <= ovs_next;
            firr_reg  <= firr_next;
            pzo_reg   <= pzo_next;
            szo_reg   <= szo_next;
        end
    end

    // Datapath outputs
    assign left_atten_level    = attl_reg;
    assign right_atten_level   = attr_reg;
    assign left_atten_mute     = mutel_reg;
    assign right_atten_mute    = muter_reg;
    assign atten_step_rate     = step_reg;
    assign audio_format_sel    = form_reg;
    assign deemph_rate_sel     = rate_reg;
    assign deemph_enable       = emph_reg;
    assign soft_mute           = smute_reg;
    assign rolloff_sel         = roll_reg;
    assign bypass_stereo_sel   = byst_reg;
    assign phase_invert        = inv_reg;
    assign converter_disable   = dis_reg;
    assign zero_pin_function   = zpin_reg;
    assign infinite_zero_mute  = izm_reg;
    assign soft_system_reset   = sres_reg;
    assign one_bit_stream_mode = strm_reg;
    assign filter_bypass       = byp_reg;
    assign mono_mode           = mono_reg;
    assign mono_source_sel     = src_reg;
    assign oversample_rate_sel = ovs_reg;
    assign fir_perf_sel        = firp_reg;
    assign fir_rate_sel        = firr_reg;
    assign pcm_zero_out_enable = pzo_reg;
    assign stream_zero_out_sel = szo_reg;

endmodule : admc_regs

// ===== rtl/admc_serial_port.sv
// Purpose: Four-wire control port framing: 16-bit word in, readback out
// Assumes: ms_n, mc, mdi synchronous to clk; mc phases at least 1 clock
// Notes:   Write pulse after 16th rising mc; readback from 8th falling mc
`timescale 1ns/10ps
module admc_serial_port
    import admc_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       reset,
    // Control port pins
    input  wire logic       ms_n,
    input  wire logic       mc,
    input  wire logic       mdi,
    output logic            mdo,
    // Register side
    input  wire logic [7:0] rd_data,
    output logic [6:0]      cmd_index,
    output logic            cmd_rw,
    output logic            wr_valid,
    output logic [7:0]      wr_data
);

    admc_port_state_t state_reg, state_next;   // Framing state
    logic [4:0]  cnt_reg, cnt_next;            // Rising edges seen
    logic [15:0] in_sr_reg, in_sr_next;        // Incoming word
    logic [6:0]  out_sr_reg, out_sr_next;      // Remaining readback
    logic [6:0]  idx_reg, idx_next;            // Latched index
    logic        rw_reg, rw_next;              // Latched read flag
    logic        wr_reg, wr_next;              // Write pulse
    logic        mdo_reg, mdo_next;            // Serial output bit
    logic        mc_prev_reg;                  // Previous mc level
    logic        mc_rise;
    logic        mc_fall;

    // Edge detect on the sampled bit clock
    assign mc_rise = mc & ~mc_prev_reg;
    assign mc_fall = ~mc & mc_prev_reg;

    // Next-state logic of the framer
    always_comb begin
        state_next  = state_reg;
        cnt_next    = cnt_reg;
        in_sr_next  = in_sr_reg;
        out_sr_next = out_sr_reg;
        idx_next    = idx_reg;
        rw_next     = rw_reg;
        wr_next     = 1'b0;
        mdo_next    = mdo_reg;
        case (state_reg)
            ST_IDLE: begin
                // Wait for select to go low
                cnt_next = 5'h00;
                mdo_next = 1'b0;
                if (!ms_n) begin
                    state_next = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                if (ms_n) begin
                    // Aborted frame: nothing is written
                    state_next = ST_IDLE;
                end else if (mc_rise) begin
                    in_sr_next = {in_sr_reg[14:0], mdi};
                    cnt_next   = cnt_reg + 5'h01;
                    if (cnt_reg == CNT_HDR_LAST) begin
                        // Header complete: top bit selects read
                        rw_next  = in_sr_reg[6];
                        idx_next = {in_sr_reg[5:0], mdi};
                    end
                    if (cnt_reg == CNT_LAST) begin
                        // Latch data only for a write
                        wr_next    = ~rw_reg;
                        state_next = ST_DONE;
                    end
                end else if (mc_fall && rw_reg
                             && cnt_reg >= CNT_FIRST_RD) begin
                    // Readback shifts out MSB first
                    if (cnt_reg == CNT_FIRST_RD) begin
                        mdo_next    = rd_data[7];
                        out_sr_next = rd_data[6:0];
                    end else begin
                        mdo_next    = out_sr_reg[6];
                        out_sr_next = {out_sr_reg[5:0], 1'b0};
                    end
                end
            end
            ST_DONE: begin
                // Select must return high before the next word
                if (ms_n) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // Framer registers
    always_ff @(posedge clk) begin
        if (reset) begin
            state_reg   <= ST_IDLE;
            cnt_reg     <= 5'h00;
            in_sr_reg   <= 16'h0000;
            out_sr_reg  <= 7'h00;
            idx_reg     <= 7'h00;
            rw_reg      <= 1'b0;
            wr_reg      <= 1'b0;
            mdo_reg     <= 1'b0;
            mc_prev_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            cnt_reg     <= cnt_next;
            in_sr_reg   <= in_sr_next;
            out_sr_reg  <= out_sr_next;
            idx_reg     <= idx_next;
            rw_reg      <= rw_next;
            wr_reg      <= wr_next;
            mdo_reg     <= mdo_next;
            mc_prev_reg <= mc;
        end
    end

    // Outputs straight from flops
    assign mdo       = mdo_reg;
    assign cmd_index = idx_reg;
    assign cmd_rw    = rw_reg;
    assign wr_valid  = wr_reg;
    assign wr_data   = in_sr_reg[7:0];

endmodule : admc_serial_port

// ===== sim/admc_host_model.sv
// Purpose: Host side of the four-wire control port
// Assumes: Pins change 1 ns after the clock edge
// Notes:   mc phases kept 2 to 3 clocks, well over the minimum
`timescale 1ns/10ps
module admc_host_model (
    // Clock and control port pins
    input  wire logic clk,
    output logic      ms_n,
    output logic      mc,
    output logic      mdi,
    input  wire logic mdo
);
    // Idle levels at time zero
    initial begin
        ms_n = 1'b1;
        mc = 1'b0;
        mdi = 1'b0;
    end

    // Step just past the next n edges
    task automatic tk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tk

    // One 16-bit word, MSB first; returns the readback byte
    task automatic xfer(input logic [15:0] w, output logic [7:0] rd);
        tk(1);
        ms_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            mdi = w[i]; // Top bit picks read or write
            tk(3);
            rd[i%8] = (i < 8) ? mdo : 1'b0;
            mc = 1'b1;
            tk(2);
            mc = 1'b0;
        end
        tk(3);
        ms_n = 1'b1;
        mdi = ~mdi; // No stale level on a released line
        tk(4);
    endtask : xfer
endmodule : admc_host_model

// ===== sim/admc_regs_asserts.sv
// Purpose: Port-level checks on the mode-control register bank
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound onto every admc_regs instance
`timescale 1ns/10ps
module admc_regs_asserts
    import admc_pkg::*;
(
    input wire logic       clk,
    input wire logic       reset,
    input wire logic       ms_n,
    input wire logic       mdo,
    input wire logic [7:0] left_atten_level,
    input wire logic [7:0] right_atten_level,
    input wire logic       left_atten_mute,
    input wire logic       right_atten_mute,
    input wire logic [2:0] audio_format_sel,
    input wire logic       deemph_enable,
    input wire logic       soft_mute,
    input wire logic       rolloff_sel,
    input wire logic       bypass_stereo_sel,
    input wire logic       one_bit_stream_mode,
    input wire logic       filter_bypass,
    input wire logic [1:0] oversample_rate_sel,
    input wire logic [1:0] fir_perf_sel,
    input wire logic [1:0] fir_rate_sel,
    input wire logic       pcm_zero_out_enable,
    input wire logic [1:0] stream_zero_out_sel
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (reset);
    a_mdo_idle: assert property (ms_n [*3] |-> !mdo)
        else $error("mdo not low while deselected");
    a_left_mute_code: assert property (
        left_atten_mute == (left_atten_level <= ATTEN_MUTE_MAX))
        else $error("left mute flag wrong for code");
    a_right_mute_code: assert property (
        right_atten_mute == (right_atten_level <= ATTEN_MUTE_MAX))
        else $error("right mute flag wrong for code");
    a_reset_values: assert property ($fell(reset) |->
        left_atten_level == RST_ATTEN && audio_format_sel == FORM_I2S24
        && pcm_zero_out_enable && !one_bit_stream_mode)
        else $error("settings wrong after reset");
    a_stream_fields: assert property (one_bit_stream_mode |->
        audio_format_sel == FORM_I2S24 && !filter_bypass
        && oversample_rate_sel == OVS_X64 && !pcm_zero_out_enable)
        else $error("stream mode fields wrong");
    a_pcm_only: assert property (
        one_bit_stream_mode || filter_bypass
        |-> !soft_mute && !deemph_enable && !rolloff_sel)
        else $error("PCM-only setting active");
    a_fir_gated: assert property (!one_bit_stream_mode |->
        fir_perf_sel == 2'h0 && fir_rate_sel == 2'h0
        && stream_zero_out_sel == 2'h0)
        else $error("stream fields active outside stream mode");
    a_bypass_stereo: assert property (
        !filter_bypass |-> !bypass_stereo_sel)
        else $error("stereo select outside bypass");
endmodule : admc_regs_asserts

bind admc_regs admc_regs_asserts chk_u (.clk, .reset, .ms_n, .mdo,
    .left_atten_level, .right_atten_level, .left_atten_mute,
    .right_atten_mute, .audio_format_sel, .deemph_enable, .soft_mute,
    .rolloff_sel, .bypass_stereo_sel, .one_bit_stream_mode, .filter_bypass,
    .oversample_rate_sel, .fir_perf_sel, .fir_rate_sel,
    .pcm_zero_out_enable, .stream_zero_out_sel);

// ===== sim/test_audio_dac_mode_control_registers.sv
// Purpose: Register access tests over the control port
// Assumes: Host model paces every frame
// Notes:   Node identifier value is arbitrary
`timescale 1ns/10ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
    err_count++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module test_audio_dac_mode_control_registers
    import admc_pkg::*;
;
    logic       clk, reset, ms_n, mc, mdi, mdo, lz, rz, mute_l, stream, byp;
    logic [7:0] lvl, d;
    logic [3:0] oc; // Output control bits
    logic [4:0] nid = 5'h13; // Arbitrary identifier
    int         err_count = 0, total_checks = 0, cyc = 0;
    logic [7:0] rst_v [6] = '{8'hFF, 8'hFF, 8'h50, 8'h00, 8'h00, 8'h01};
    logic [7:0] msk_v [6] = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h7F, 8'h07};
    admc_host_model host_u (.clk(clk), .ms_n(ms_n), .mc(mc), .mdi(mdi),
        .mdo(mdo));
    admc_regs dut_u (.clk(clk), .reset(reset), .ms_n(ms_n), .mc(mc),
        .mdi(mdi), .mdo(mdo), .left_zero_detect(lz), .right_zero_detect(rz),
        .node_identifier(nid), .left_atten_level(lvl), .right_atten_level(),
        .left_atten_mute(mute_l), .right_atten_mute(), .atten_step_rate(),
        .audio_format_sel(), .deemph_rate_sel(), .deemph_enable(),
        .soft_mute(), .rolloff_sel(), .bypass_stereo_sel(),
        .phase_invert(oc[3]), .converter_disable(oc[2]),
        .zero_pin_function(oc[1]), .infinite_zero_mute(oc[0]),
        .soft_system_reset(), .one_bit_stream_mode(stream), .mono_mode(),
        .filter_bypass(byp), .mono_source_sel(), .oversample_rate_sel(),
        .fir_perf_sel(), .fir_rate_sel(), .pcm_zero_out_enable(),
        .stream_zero_out_sel());
    task automatic wr(input logic [6:0] i, input logic [7:0] v);
        host_u.xfer({1'b0, i, v}, d);
    endtask : wr
    task automatic rd(input logic [6:0] i);
        host_u.xfer({1'b1, i, 8'h00}, d);
    endtask : rd
    task automatic test_done();
        $display("Checks %0d, errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // Cut a hang short
    always @(posedge clk) begin
        cyc++;
        if (cyc == 10000) begin
            err_count++;
            test_done();
        end
    end
    initial begin
        reset = 1'b1;
        lz = 1'b1;
        rz = 1'b0;
        repeat (5) @(posedge clk);
        #1 reset = 1'b0;
        for (int i = 0; i < 6; i++) begin
            rd(IDX_ATTEN_L + 7'(i));
            `CHK("reset value", rst_v[i], d)
            wr(IDX_ATTEN_L + 7'(i), 8'hA5);
            rd(IDX_ATTEN_L + 7'(i));
            `CHK("readback", 8'hA5 & msk_v[i], d)
            if (i == 0) `CHK("level held", 8'hFF, lvl)
        end
        `CHK("stream mode", 1'b1, stream)
        wr(IDX_MODE, 8'h10);
        `CHK("bypass mode", 1'b1, byp)
        wr(IDX_MODE, 8'h00);
        `CHK("level loaded", 8'hA5, lvl)
        `CHK("output ctrl", 4'h9, oc)
        wr(IDX_FORMAT, 8'h00);
        wr(IDX_ATTEN_L, 8'h0E);
        `CHK("level frozen", 8'hA5, lvl)
        wr(IDX_FORMAT, 8'h80);
        `CHK("mute code", 1'b1, mute_l)
        wr(IDX_ZFLAGS, 8'hFF);
        wr(IDX_NODE_ID, 8'hFF);
        rd(IDX_ZFLAGS);
        `CHK("zero flags", 8'h01, d)
        lz = 1'b0;
        rz = 1'b1;
        rd(IDX_ZFLAGS);
        `CHK("zero flags", 8'h02, d)
        rd(IDX_NODE_ID);
        `CHK("node id", {3'h0, nid}, d)
        wr(7'h30, 8'hFF);
        rd(7'h30);
        `CHK("unlisted", 8'h00, d)
        test_done();
    end
endmodule : test_audio_dac_mode_control_registers
